// file: design/power_bank_consts.svh
// Offsets, field positions, reset values and masks of the power enable bank.
// Assumes 16-bit registers reached by word index; byte address is 4x index.
`ifndef POWER_BANK_CONSTS_SVH
`define POWER_BANK_CONSTS_SVH

`define IDX_CHIP_ID       14'h0000
`define IDX_MIC_CONV      14'h0003
`define IDX_INPUT_CH      14'h0004
`define IDX_PATH_CONV     14'h0005
`define IDX_OUTPUT_CH     14'h0006
`define IDX_MIC_DETECT    14'h0038
`define IDX_CHARGE_PUMP   14'h0040
`define IDX_SERVO         14'h0050
`define IDX_SEQ_CTRL      14'h0110
`define IDX_INTF_CLOCKING 14'h0200
`define IDX_CLOCK_ENA     14'h0208
`define IDX_FREQ_LOOP     14'h0220
`define IDX_SEQ_MEM_FIRST 14'h3000
`define IDX_SEQ_MEM_LAST  14'h31ff

`define MASK_MIC_CONV      16'h000f
`define MASK_INPUT_CH      16'h033f
`define MASK_PATH_CONV     16'h0f0f
`define MASK_OUTPUT_CH     16'h033f
`define MASK_MIC_DETECT    16'h0001
`define MASK_CHARGE_PUMP   16'h8000
`define MASK_SERVO         16'h000f
`define MASK_SEQ_CTRL      16'h0100
`define MASK_INTF_CLOCKING 16'h0001
`define MASK_CLOCK_ENA     16'h0016
`define MASK_FREQ_LOOP     16'h0001

`define RST_MIC_DETECT     16'h7600
`define RST_CHARGE_PUMP    16'h1f25
`define RST_ZERO           16'h0000

`define BIT_SEQ_ENABLE     8
`define BIT_SLOW_CLOCK     4
`define BIT_INTF_CLOCK     2
`define BIT_FILTER_CLOCK   1
`define BIT_CHARGE_PUMP    15

`define RESP_OKAY          2'h0
`define RESP_DECODE_ERROR  2'h3

`endif

// file: design/power_bank_pkg.sv
// Types of the power enable bank.
// Assumes power_bank_consts.svh is compiled first.
package power_bank_pkg;

   localparam int NUM_SLOTS = 11;

   typedef enum logic [3:0] {
      SLOT_MIC_CONV,
      SLOT_INPUT_CH,
      SLOT_PATH_CONV,
      SLOT_OUTPUT_CH,
      SLOT_MIC_DETECT,
      SLOT_CHARGE_PUMP,
      SLOT_SERVO,
      SLOT_SEQ_CTRL,
      SLOT_INTF_CLOCKING,
      SLOT_CLOCK_ENA,
      SLOT_FREQ_LOOP
   } slot_t;

   typedef struct packed {
      logic [NUM_SLOTS-1:0][15:0] regs;
      logic                       waitrequest;
      logic [31:0]                readdata;
      logic [1:0]                 response;
      logic                       configured;
      logic                       blocks_in_reset;
      logic                       control_ready;
      logic [1:0]                 capture_out_oe_n;
      logic                       pin_pulldown;
      logic                       clock_pins_input;
      logic                       zero_cross_allow;
   } bank_state_t;

endpackage

// file: design/power_enable_reset_bank.sv
// Power enable register bank with supply-held reset, soft reset and part code.
// Assumes an Avalon-MM master with byte addresses and 32-bit data, and
// supply detector levels that are synchronous to clk.
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "power_bank_consts.svh"

module power_enable_reset_bank #(
   // Part code read back at index 0; the default value is arbitrary.
   parameter logic [15:0] CHIP_ID   = 16'h5a3c,
   parameter int          SEQ_DEPTH = 512
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [15:0] address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output logic             waitrequest,
   output logic [31:0]      readdata,
   output logic [1:0]       response,
   input  wire logic        core_supply_ok,
   input  wire logic        interface_supply_ok,
   input  wire logic        analog_supply_ok,
   output logic             control_ready,
   output logic             blocks_in_reset,
   output logic             first_pdm_mic_left_enable,
   output logic             first_pdm_mic_right_enable,
   output logic             left_converter_enable,
   output logic             right_converter_enable,
   output logic [1:0]       second_intf_in_enable,
   output logic [5:0]       first_intf_in_enable,
   output logic [3:0]       filter_out_enable,
   output logic [3:0]       dac_enable,
   output logic [1:0]       second_intf_out_enable,
   output logic [5:0]       first_intf_out_enable,
   output logic             mic_detect_enable,
   output logic             charge_pump_enable,
   output logic [3:0]       servo_enable,
   output logic             sequencer_enable,
   output logic             system_clock_enable,
   output logic             slow_timeout_clock_enable,
   output logic             interface_clock_enable,
   output logic             filter_engine_clock_enable,
   output logic             freq_loop_enable,
   output logic             zero_cross_timeout_allow,
   output logic [1:0]       capture_out_oe_n,
   output logic             speaker_pdm_clock_pulldown,
   output logic             speaker_pdm_data_pulldown,
   output logic             gpio_pulldown,
   output logic             address_pin_pulldown,
   output logic             clock_pins_input_mode
);

   localparam int SEQ_AW = $clog2(SEQ_DEPTH);

   // ----------------------------------------------------------------------
   // Register table helpers
   // ----------------------------------------------------------------------

   // Maps a word index to a slot of the table, with a hit flag.
   function automatic logic [4:0] slot_of(input logic [13:0] idx);
      logic [4:0] r;
      r = {1'b1, 4'(power_bank_pkg::SLOT_MIC_CONV)};
      case (idx)
         `IDX_MIC_CONV:      r = {1'b1, 4'(power_bank_pkg::SLOT_MIC_CONV)};
         `IDX_INPUT_CH:      r = {1'b1, 4'(power_bank_pkg::SLOT_INPUT_CH)};
         `IDX_PATH_CONV:     r = {1'b1, 4'(power_bank_pkg::SLOT_PATH_CONV)};
         `IDX_OUTPUT_CH:     r = {1'b1, 4'(power_bank_pkg::SLOT_OUTPUT_CH)};
         `IDX_MIC_DETECT:    r = {1'b1, 4'(power_bank_pkg::SLOT_MIC_DETECT)};
         `IDX_CHARGE_PUMP:   r = {1'b1, 4'(power_bank_pkg::SLOT_CHARGE_PUMP)};
         `IDX_SERVO:         r = {1'b1, 4'(power_bank_pkg::SLOT_SERVO)};
         `IDX_SEQ_CTRL:      r = {1'b1, 4'(power_bank_pkg::SLOT_SEQ_CTRL)};
         `IDX_INTF_CLOCKING: r = {1'b1,
                                  4'(power_bank_pkg::SLOT_INTF_CLOCKING)};
         `IDX_CLOCK_ENA:     r = {1'b1, 4'(power_bank_pkg::SLOT_CLOCK_ENA)};
         `IDX_FREQ_LOOP:     r = {1'b1, 4'(power_bank_pkg::SLOT_FREQ_LOOP)};
         default:            r = 5'h00;
      endcase
      return r;
   endfunction

   // Writable bits of each slot; all other bits keep their reset value.
   function automatic logic [15:0] slot_mask(input int s);
      logic [15:0] m;
      case (s)
         0:       m = `MASK_MIC_CONV;
         1:       m = `MASK_INPUT_CH;
         2:       m = `MASK_PATH_CONV;
         3:       m = `MASK_OUTPUT_CH;
         4:       m = `MASK_MIC_DETECT;
         5:       m = `MASK_CHARGE_PUMP;
         6:       m = `MASK_SERVO;
         7:       m = `MASK_SEQ_CTRL;
         8:       m = `MASK_INTF_CLOCKING;
         9:       m = `MASK_CLOCK_ENA;
         10:      m = `MASK_FREQ_LOOP;
         default: m = 16'h0000;
      endcase
      return m;
   endfunction

   // Reset value of each slot.
   function automatic logic [15:0] slot_default(input int s);
      logic [15:0] d;
      case (s)
         4:       d = `RST_MIC_DETECT;
         5:       d = `RST_CHARGE_PUMP;
         default: d = `RST_ZERO;
      endcase
      return d;
   endfunction

   function automatic power_bank_pkg::bank_state_t reset_state();
      power_bank_pkg::bank_state_t s;
      s = '0;
      for (int i = 0; i < power_bank_pkg::NUM_SLOTS; i++)
      begin
         s.regs[i] = slot_default(i);
      end
      s.waitrequest      = 1'b1;
      s.blocks_in_reset  = 1'b1;
      s.capture_out_oe_n = 2'h3;
      s.pin_pulldown     = 1'b1;
      s.clock_pins_input = 1'b1;
      return s;
   endfunction

   // Expands the two low byte enables into a 16-bit lane mask.
   function automatic logic [15:0] lane_mask(input logic [1:0] be);
      return {{8{be[1]}}, {8{be[0]}}};
   endfunction

   // Reset image of the whole state, kept as a constant so that the
   // asynchronous reset branch loads nothing but constants.
   localparam power_bank_pkg::bank_state_t RESET_VALUE = reset_state();

   // ----------------------------------------------------------------------
   // Sequencer program storage
   // ----------------------------------------------------------------------

   // The sequencer words sit outside the state struct and have no reset,
   // so their content survives all three kinds of reset.
   logic [15:0] seq_mem [SEQ_DEPTH];

   power_bank_pkg::bank_state_t state;
   power_bank_pkg::bank_state_t next_state;

   // ----------------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------------

   logic [13:0]       idx;
   logic [4:0]        hit;
   logic              in_seq;
   logic [SEQ_AW-1:0] seq_addr;
   logic              accept;
   logic              supplies_ok;

   assign idx         = address[15:2];
   assign hit         = slot_of(idx);
   assign in_seq      = (idx >= `IDX_SEQ_MEM_FIRST) &&
                        (idx <= `IDX_SEQ_MEM_LAST);
   assign seq_addr    = SEQ_AW'(idx - `IDX_SEQ_MEM_FIRST);
   // A request is taken in the cycle in which waitrequest is low.
   assign accept      = (read || write) && !state.waitrequest;
   assign supplies_ok = core_supply_ok && interface_supply_ok;

   // Only full-word writes reach the storage, so no half word is stored.
   // storage has no reset path
   always_ff @(posedge clk)
   begin
      if (accept && write && in_seq && byteenable[1:0] == 2'h3)
      begin
         seq_mem[seq_addr] <= writedata[15:0];
      end
   end

   // ----------------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------------

   always_comb
   begin
      logic [15:0] m;
      logic [15:0] wd;
      m  = 16'h0000;
      wd = 16'h0000;
      next_state = state;
      // Waitrequest is low for one cycle per answer.
      next_state.waitrequest = 1'b1;
      if (!supplies_ok)
      begin
         next_state = reset_state();
      end
      else if (accept && write && idx == `IDX_CHIP_ID)
      begin
         // any write to index 0 resets
         next_state = reset_state();
         next_state.configured = 1'b0;
         // The bus stays open, so later requests are still answered.
         next_state.control_ready = 1'b1;
      end
      else
      begin
         next_state.control_ready = 1'b1;
         if (accept && write && hit[4])
         begin
            m = slot_mask(int'(hit[3:0]));
            wd = writedata[15:0] & lane_mask(byteenable[1:0]);
            m = m & lane_mask(byteenable[1:0]);
            next_state.regs[hit[3:0]] = (state.regs[hit[3:0]] & ~m) |
                                        (wd & m);
            // The first configuring write frees pull-downs and clock pins; each capture output also needs its output channel bits set.
            next_state.configured = 1'b1;
         end
         // The answer is prepared in the cycle the request is first seen.
         if ((read || write) && state.waitrequest)
         begin
            next_state.waitrequest = 1'b0;
            next_state.response = `RESP_OKAY;
            next_state.readdata = 32'h0000_0000;
            if (idx == `IDX_CHIP_ID)
            begin
               next_state.readdata = {16'h0000, CHIP_ID};
            end
            else if (hit[4])
            begin
               next_state.readdata = {16'h0000, state.regs[hit[3:0]]};
            end
            else if (in_seq)
            begin
               next_state.readdata = {16'h0000, seq_mem[seq_addr]};
            end
            else
            begin
               next_state.response = `RESP_DECODE_ERROR;
            end
         end
      end
      // The other blocks also wait for their own supply.
      next_state.blocks_in_reset = !(supplies_ok && analog_supply_ok);
      next_state.pin_pulldown = !next_state.configured;
      next_state.clock_pins_input = !next_state.configured;
      next_state.capture_out_oe_n[0] = !(next_state.configured &&
         |(next_state.regs[power_bank_pkg::SLOT_OUTPUT_CH][5:0]));
      next_state.capture_out_oe_n[1] = !(next_state.configured &&
         |(next_state.regs[power_bank_pkg::SLOT_OUTPUT_CH][9:8]));
      // timeout allowed only with slow clock
      next_state.zero_cross_allow =
         next_state.regs[power_bank_pkg::SLOT_CLOCK_ENA][`BIT_SLOW_CLOCK];
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state <= RESET_VALUE;
      end
      else
      begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------------
   // Bus outputs
   // ----------------------------------------------------------------------

   // Every output is a bit of the state register, with no logic after it.
   assign waitrequest     = state.waitrequest;
   assign readdata        = state.readdata;
   assign response        = state.response;
   assign control_ready   = state.control_ready;
   assign blocks_in_reset = state.blocks_in_reset;

   // ----------------------------------------------------------------------
   // Enable outputs
   // ----------------------------------------------------------------------

   assign first_pdm_mic_left_enable  =
      state.regs[power_bank_pkg::SLOT_MIC_CONV][3];
   assign first_pdm_mic_right_enable =
      state.regs[power_bank_pkg::SLOT_MIC_CONV][2];
   assign left_converter_enable      =
      state.regs[power_bank_pkg::SLOT_MIC_CONV][1];
   assign right_converter_enable     =
      state.regs[power_bank_pkg::SLOT_MIC_CONV][0];
   assign second_intf_in_enable  =
      state.regs[power_bank_pkg::SLOT_INPUT_CH][9:8];
   assign first_intf_in_enable   =
      state.regs[power_bank_pkg::SLOT_INPUT_CH][5:0];
   assign filter_out_enable = state.regs[power_bank_pkg::SLOT_PATH_CONV][11:8];
   assign dac_enable        = state.regs[power_bank_pkg::SLOT_PATH_CONV][3:0];
   assign second_intf_out_enable =
      state.regs[power_bank_pkg::SLOT_OUTPUT_CH][9:8];
   assign first_intf_out_enable  =
      state.regs[power_bank_pkg::SLOT_OUTPUT_CH][5:0];
   assign mic_detect_enable  = state.regs[power_bank_pkg::SLOT_MIC_DETECT][0];
   assign charge_pump_enable =
      state.regs[power_bank_pkg::SLOT_CHARGE_PUMP][`BIT_CHARGE_PUMP];
   assign servo_enable = state.regs[power_bank_pkg::SLOT_SERVO][3:0];
   assign sequencer_enable =
      state.regs[power_bank_pkg::SLOT_SEQ_CTRL][`BIT_SEQ_ENABLE];
   // Gate of the system clock, a plain register bit.
   assign system_clock_enable =
      state.regs[power_bank_pkg::SLOT_INTF_CLOCKING][0];
   assign slow_timeout_clock_enable =
      state.regs[power_bank_pkg::SLOT_CLOCK_ENA][`BIT_SLOW_CLOCK];
   assign interface_clock_enable =
      state.regs[power_bank_pkg::SLOT_CLOCK_ENA][`BIT_INTF_CLOCK];
   assign filter_engine_clock_enable =
      state.regs[power_bank_pkg::SLOT_CLOCK_ENA][`BIT_FILTER_CLOCK];
   assign freq_loop_enable = state.regs[power_bank_pkg::SLOT_FREQ_LOOP][0];
   assign zero_cross_timeout_allow = state.zero_cross_allow;

   // ----------------------------------------------------------------------
   // Pin controls
   // ----------------------------------------------------------------------

   assign capture_out_oe_n           = state.capture_out_oe_n;
   assign speaker_pdm_clock_pulldown = state.pin_pulldown;
   assign speaker_pdm_data_pulldown  = state.pin_pulldown;
   assign gpio_pulldown              = state.pin_pulldown;
   assign address_pin_pulldown       = state.pin_pulldown;
   assign clock_pins_input_mode      = state.clock_pins_input;

endmodule

`default_nettype wire

// file: sim/power_bank_sva.sv
// Assertions on supply reset, soft reset, part code and enable writes.
// Assumes a bind into power_enable_reset_bank, matching its port names.
`timescale 1ns/1ps
`default_nettype none
module power_bank_sva #(
   parameter logic [15:0] CHIP_ID = 16'h0000
) (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic [15:0] address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] writedata,
   input wire logic [3:0]  byteenable,
   input wire logic        waitrequest,
   input wire logic [31:0] readdata,
   input wire logic [1:0]  response,
   input wire logic        core_supply_ok,
   input wire logic        interface_supply_ok,
   input wire logic        analog_supply_ok,
   input wire logic        control_ready,
   input wire logic        blocks_in_reset,
   input wire logic [3:0]  dac_enable,
   input wire logic [3:0]  servo_enable,
   input wire logic        sequencer_enable,
   input wire logic        slow_timeout_clock_enable,
   input wire logic        interface_clock_enable,
   input wire logic        filter_engine_clock_enable,
   input wire logic        zero_cross_timeout_allow,
   input wire logic [1:0]  capture_out_oe_n,
   input wire logic        gpio_pulldown,
   input wire logic        clock_pins_input_mode
);
   logic        wr_go;
   logic        rd_go;
   logic [31:0] wd_q;
   assign wr_go = write && !waitrequest;
   assign rd_go = read && !waitrequest;
   always_ff @(posedge clk)
   begin
      wd_q <= writedata;
   end
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   // ------------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------------
   chk_supply_hold: assert property (
      !(core_supply_ok && interface_supply_ok)
      |=> !control_ready && waitrequest)
      else $error("bank answered without both supplies");
   chk_blocks_held: assert property (
      !analog_supply_ok |=> blocks_in_reset)
      else $error("blocks left reset without their supply");
   chk_soft_clear: assert property (
      wr_go && address[15:2] == 14'h0000 |=> {dac_enable, servo_enable,
      sequencer_enable, slow_timeout_clock_enable, interface_clock_enable,
      filter_engine_clock_enable} == 12'h000)
      else $error("enables survived a soft reset");
   chk_soft_pins: assert property (
      wr_go && address[15:2] == 14'h0000 |=> capture_out_oe_n == 2'h3
      && gpio_pulldown && clock_pins_input_mode)
      else $error("pins not in reset state after soft reset");
   chk_unready_pins: assert property (
      !control_ready |-> capture_out_oe_n == 2'h3 && gpio_pulldown)
      else $error("pins driven while held in reset");
   chk_id_read: assert property (
      rd_go && address[15:2] == 14'h0000 |-> (readdata == {16'h0000, CHIP_ID}
      && response == 2'h0) ##1 $stable(servo_enable))
      else $error("part code read wrong or disturbed state");
   chk_servo_write: assert property (
      wr_go && address == 16'h0140 && byteenable[0]
      |=> servo_enable == wd_q[3:0])
      else $error("servo enables not written");
   chk_seq_write: assert property (
      wr_go && address == 16'h0440 && byteenable[1]
      |=> sequencer_enable == wd_q[8])
      else $error("sequencer enable not written");
   chk_clock_write: assert property (
      wr_go && address == 16'h0820 && byteenable[0]
      |=> {slow_timeout_clock_enable, interface_clock_enable,
      filter_engine_clock_enable} == {wd_q[4], wd_q[2:1]})
      else $error("clock enables not written");
   chk_zero_cross: assert property (
      zero_cross_timeout_allow == slow_timeout_clock_enable)
      else $error("zero-cross timeout allowed without slow clock");
endmodule
bind power_enable_reset_bank power_bank_sva #(.CHIP_ID(CHIP_ID)) sva_u (.*);
`default_nettype wire

// file: sim/host_master.sv
// Host model: an Avalon-MM master for the bank's register bus.
// Assumes its task is entered from the bench's clock domain.
`timescale 1ns/1ps
`default_nettype none
module host_master (
   input  wire logic        clk,
   input  wire logic        waitrequest,
   input  wire logic [31:0] readdata,
   input  wire logic [1:0]  response,
   output logic [15:0]      address,
   output logic             read,
   output logic             write,
   output logic [31:0]      writedata,
   output logic [3:0]       byteenable
);
   initial
   begin
      address = 16'h0000;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0000_0000;
      byteenable = 4'h0;
   end
   // Holds the request until waitrequest is seen low; released lines toggle.
   task automatic acc(input logic wr, input logic [15:0] a,
                      input logic [15:0] d, input logic [3:0] be,
                      output logic [15:0] q,
                      output logic [1:0] r);
      @(posedge clk);
      address <= a;
      writedata <= {16'h0000, d};
      byteenable <= be;
      read <= !wr;
      write <= wr;
      @(posedge clk);
      while (waitrequest)
      begin
         @(posedge clk);
      end
      q = readdata[15:0];
      r = response;
      read <= 1'b0;
      write <= 1'b0;
      address <= ~a;
      writedata <= ~writedata;
   endtask
endmodule
`default_nettype wire

// file: sim/power_enable_reset_bank_tb.sv
// Self-checking bench of the power enable bank with a host bus model.
// Assumes host_master and power_bank_sva are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module power_enable_reset_bank_tb;
   // Arbitrary part code for this bench.
   localparam logic [15:0] ID = 16'h1234;
   localparam logic [13:0] IDX [11] = '{14'h0003, 14'h0004, 14'h0005,
      14'h0006, 14'h0038, 14'h0040, 14'h0050, 14'h0110, 14'h0200, 14'h0208,
      14'h0220};
   localparam logic [15:0] MSK [11] = '{16'h000f, 16'h033f, 16'h0f0f,
      16'h033f, 16'h0001, 16'h8000, 16'h000f, 16'h0100, 16'h0001, 16'h0016,
      16'h0001};
   localparam logic [15:0] DEF [11] = '{16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h7600, 16'h1f25, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000};
   logic clk, rst, read, write, waitrequest, control_ready, blocks_in_reset;
   logic core_supply_ok, interface_supply_ok, analog_supply_ok;
   logic first_pdm_mic_left_enable, first_pdm_mic_right_enable;
   logic left_converter_enable, right_converter_enable, mic_detect_enable;
   logic charge_pump_enable, sequencer_enable, system_clock_enable;
   logic slow_timeout_clock_enable, interface_clock_enable, freq_loop_enable;
   logic filter_engine_clock_enable, zero_cross_timeout_allow, gpio_pulldown;
   logic speaker_pdm_clock_pulldown, speaker_pdm_data_pulldown;
   logic address_pin_pulldown, clock_pins_input_mode;
   logic [15:0] address, q, s1, s2;
   logic [31:0] writedata, readdata, lf;
   logic [3:0]  byteenable, filter_out_enable, dac_enable, servo_enable;
   logic [1:0]  response, r, second_intf_in_enable, second_intf_out_enable;
   logic [1:0]  capture_out_oe_n;
   logic [5:0]  first_intf_in_enable, first_intf_out_enable;
   logic [15:0] m [11];
   int          bad_count = 0;
   int          cmp_count = 0;
   power_enable_reset_bank #(.CHIP_ID(ID)) dut_u (.*);
   host_master host_u (.*);
   // ------------------------------------------------------------------
   // Checking helpers
   // ------------------------------------------------------------------
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [39:0] expv();
      return {m[0][3:0], m[1][9:8], m[1][5:0], m[2][11:8], m[2][3:0],
         m[3][9:8], m[3][5:0], m[4][0], m[5][15], m[6][3:0], m[7][8], m[8][0],
         m[9][4], m[9][2:1], m[10][0]};
   endfunction
   task automatic chk(input logic [39:0] g, input logic [39:0] e);
      cmp_count++;
      if (g !== e)
      begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic acc(input logic wr, input logic [13:0] x,
                      input logic [15:0] d, input logic [3:0] be);
      logic [15:0] bm;
      bm = {{8{be[1]}}, {8{be[0]}}} & 16'hffff;
      host_u.acc(wr, {x, 2'h0}, d, be, q, r);
      for (int i = 0; i < 11; i++)
      begin
         if (wr && x == IDX[i])
         begin
            m[i] = (m[i] & ~(MSK[i] & bm)) | (d & MSK[i] & bm);
         end
      end
      if (wr && x == 14'h0000)
      begin
         m = DEF;
      end
   endtask
   task automatic rd_all();
      for (int i = 0; i < 11; i++)
      begin
         acc(1'b0, IDX[i], 16'h0000, 4'h3);
         chk({r, q}, {2'h0, m[i]});
      end
      chk({first_pdm_mic_left_enable, first_pdm_mic_right_enable,
         left_converter_enable, right_converter_enable, second_intf_in_enable,
         first_intf_in_enable, filter_out_enable, dac_enable,
         second_intf_out_enable, first_intf_out_enable, mic_detect_enable,
         charge_pump_enable, servo_enable, sequencer_enable,
         system_clock_enable, slow_timeout_clock_enable,
         interface_clock_enable, filter_engine_clock_enable,
         freq_loop_enable}, expv());
      chk(zero_cross_timeout_allow, m[9][4]);
   endtask
   task automatic pins(input logic [6:0] e);
      chk({capture_out_oe_n, speaker_pdm_clock_pulldown,
         speaker_pdm_data_pulldown, gpio_pulldown, address_pin_pulldown,
         clock_pins_input_mode}, e);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ------------------------------------------------------------------
   // Stimulus
   // ------------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      bad_count++;
      conclude();
   end
   initial
   begin
      rst = 1'b1;
      core_supply_ok = 1'b0;
      interface_supply_ok = 1'b0;
      analog_supply_ok = 1'b0;
      lf = 32'he7fb;
      m = DEF;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      chk({control_ready, blocks_in_reset}, 2'h1);
      core_supply_ok <= 1'b1;
      repeat (3) @(posedge clk);
      chk({control_ready, blocks_in_reset}, 2'h1);
      interface_supply_ok <= 1'b1;
      repeat (3) @(posedge clk);
      chk({control_ready, blocks_in_reset}, 2'h3);
      analog_supply_ok <= 1'b1;
      repeat (3) @(posedge clk);
      chk({control_ready, blocks_in_reset}, 2'h2);
      $display("supply test done");
      rd_all();
      pins(7'h7f);
      acc(1'b1, 14'h0006, 16'h0001, 4'h3);
      @(posedge clk);
      pins(7'h40);
      $display("default test done");
      for (int k = 0; k < 44; k++)
      begin
         lf = nxt(lf);
         acc(1'b1, IDX[k % 11], lf[15:0],
             {2'h0, lf[17:16] | {1'b0, k < 11}});
      end
      acc(1'b0, 14'h0000, 16'h0000, 4'h3);
      chk({r, q}, {2'h0, ID});
      rd_all();
      acc(1'b1, 14'h0007, lf[15:0], 4'h3);
      chk(r, 2'h3);
      acc(1'b0, 14'h0007, 16'h0000, 4'h3);
      chk({r, q}, {2'h3, 16'h0000});
      $display("random test done");
      s1 = lf[31:16];
      s2 = ~lf[15:0];
      acc(1'b1, 14'h3000, s1, 4'h3);
      acc(1'b1, 14'h31ff, s2, 4'h3);
      acc(1'b1, 14'h0000, lf[15:0], 4'h3);
      rd_all();
      pins(7'h7f);
      acc(1'b0, 14'h3000, 16'h0000, 4'h3);
      chk(q, s1);
      acc(1'b0, 14'h31ff, 16'h0000, 4'h3);
      chk(q, s2);
      $display("soft reset test done");
      conclude();
   end
endmodule
`default_nettype wire
